/* inc/card_fault_supervisor_defs.svh */
// Constants of the card fault supervisor: offsets, fields, reset values, timing
`ifndef CARD_FAULT_SUPERVISOR_DEFS_SVH
`define CARD_FAULT_SUPERVISOR_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CFS_CLK_PERIOD_NS   5
`define CFS_T_UNIT_NS       25000
`define CFS_DEBOUNCE_NS     8000000
`define CFS_T_CYCLES        (`CFS_T_UNIT_NS / `CFS_CLK_PERIOD_NS)
`define CFS_DEBOUNCE_CYCLES (`CFS_DEBOUNCE_NS / `CFS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CFS_ADDR_W          4
`define CFS_DATA_W          8
`define CFS_OFS_EVENT       4'h0
`define CFS_OFS_MASK        4'h1
`define CFS_OFS_STATE       4'h2

// ----------------------------------------------------------------------------
// Event and mask fields
// ----------------------------------------------------------------------------
`define CFS_EV_FAULT        0
`define CFS_EV_INSERT       1
`define CFS_EV_EXTRACT      2
`define CFS_EV_POR          3
`define CFS_EV_W            4

// ----------------------------------------------------------------------------
// State register fields
// ----------------------------------------------------------------------------
`define CFS_ST_FAULT_N      0
`define CFS_ST_PRESENT      1
`define CFS_ST_SESSION      2
`define CFS_ST_LEVEL_LO     3
`define CFS_ST_LEVEL_HI     4
`define CFS_ST_SEQ_LO       5
`define CFS_ST_SEQ_HI       6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CFS_RST_EVENT       4'h0
`define CFS_RST_MASK        4'h0

`endif

/* inc/card_fault_supervisor_pkg.sv */
// Types of the card fault supervisor
package card_fault_supervisor_pkg;

    typedef enum logic [1:0] {
        VCC_3V0 = 2'h0,
        VCC_5V0 = 2'h1,
        VCC_1V8 = 2'h2
    } vcc_level_e;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'h0,
        SEQ_ACTIVE = 2'h1,
        SEQ_DEACT  = 2'h3,
        SEQ_HOLD   = 2'h2
    } seq_state_e;

endpackage

/* hdl/cfs_sync2.sv */
// Two-flop synchroniser for a group of asynchronous inputs
module cfs_sync2 #(
    parameter int          W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

/* hdl/card_fault_supervisor.sv */
// Card fault supervisor: fault monitor, presence debounce, deactivation, supply select
//
// Function
// - Five fault sources are watched: supply overcurrent, card removal, logic supply drop, converter out of range and overheating.
// - With the power command high the fault output is low without a card and high with one.
// - A logic supply drop outside a session gives an internal reset pulse and leaves the fault output alone.
// - Overcurrent and overheating are not flagged while no session runs.
// - In a session the fault output goes low as soon as any fault is seen.
// - A session fault starts emergency deactivation without any host command.
// - After a fault, with the command high again and deactivation done, the fault output returns high if a card is present.
// - Card insertion is debounced for 8 ms and the fault output rises only at its end.
// - Extraction, once neither presence input shows a card any more, deactivates at once and drives the fault output low.
// - A high low-voltage select gives 1.8 V and ignores the high-voltage select.
// - With low-voltage select low, high-voltage select high gives 5 V and low gives 3 V.
// - Deactivation drops card reset, then clock at 0.5 T, I/O at T and supply at 1.5 T, then goes inactive.
// - The sequencer unit T is 5000 core clock periods of 5 ns, 25 us.
//
// Added by the designer: the register offsets and the plain strobed port.
`include "card_fault_supervisor_defs.svh"

module card_fault_supervisor #(
    parameter int T_CYCLES        = `CFS_T_CYCLES,
    parameter int DEBOUNCE_CYCLES = `CFS_DEBOUNCE_CYCLES
) (
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              card_power_cmd_n,
    input  wire logic [1:0]                        card_detect_in,
    input  wire logic                              low_volt_select,
    input  wire logic                              high_volt_select,
    input  wire logic                              vcc_overcurrent,
    input  wire logic                              vdd_drop,
    input  wire logic                              converter_fault,
    input  wire logic                              over_temp,
    input  wire logic [`CFS_ADDR_W-1:0]            reg_addr,
    input  wire logic [`CFS_DATA_W-1:0]            reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [`CFS_DATA_W-1:0]            reg_rdata,
    output logic                                   fault_n,
    output logic                                   por_pulse,
    output logic                                   card_rst_en,
    output logic                                   card_clk_en,
    output logic                                   card_io_en,
    output logic                                   vcc_en,
    output card_fault_supervisor_pkg::vcc_level_e  vcc_level,
    output logic                                   irq
);
    import card_fault_supervisor_pkg::*;

    // ------------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------------
    localparam int SEQ_W = $clog2(2 * T_CYCLES + 1);
    localparam int DB_W  = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [SEQ_W-1:0] HALF_T_END = SEQ_W'((T_CYCLES / 2) - 1);
    localparam logic [SEQ_W-1:0] FULL_T_END = SEQ_W'(T_CYCLES - 1);
    localparam logic [SEQ_W-1:0] T15_END    = SEQ_W'(((3 * T_CYCLES) / 2) - 1);
    localparam logic [DB_W-1:0]  DB_END     = DB_W'(DEBOUNCE_CYCLES - 1);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic        cmd_n_s;
    logic [1:0]  detect_s;
    logic        lv_sel_s;
    logic        hv_sel_s;
    logic [3:0]  flt_s;

    cfs_sync2 #(.W(5), .RESET_VAL(5'h18)) u_sync_ctl (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({card_power_cmd_n, card_detect_in, low_volt_select, high_volt_select}),
        .q        ({cmd_n_s, detect_s, lv_sel_s, hv_sel_s})
    );

    cfs_sync2 #(.W(4), .RESET_VAL(4'h0)) u_sync_flt (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({vcc_overcurrent, vdd_drop, converter_fault, over_temp}),
        .q        (flt_s)
    );

    // Bit 0 switch is active high, bit 1 switch is active low
    logic present_raw;
    assign present_raw = detect_s[0] | ~detect_s[1];

    // ------------------------------------------------------------------------
    // Presence debounce
    // ------------------------------------------------------------------------
    logic [DB_W-1:0] db_cnt_q;
    logic            present_q;
    logic            extract_evt;
    logic            insert_evt;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            db_cnt_q  <= '0;
            present_q <= 1'b0;
        end else if (!present_raw) begin
            db_cnt_q  <= '0;
            present_q <= 1'b0;
        end else if (!present_q) begin
            if (db_cnt_q == DB_END) begin
                db_cnt_q  <= '0;
                present_q <= 1'b1;
            end else begin
                db_cnt_q <= db_cnt_q + DB_W'(1);
            end
        end
    end

    assign extract_evt = present_q & ~present_raw;
    assign insert_evt  = ~present_q & present_raw & (db_cnt_q == DB_END);

    // ------------------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------------------
    seq_state_e state_q;
    logic       in_session;
    logic       fault_src;
    logic       session_fault;
    logic       vdd_drop_prev_q;

    assign in_session    = (state_q != SEQ_IDLE);
    assign fault_src     = |flt_s | extract_evt;
    assign session_fault = in_session & fault_src;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vdd_drop_prev_q <= 1'b0;
            por_pulse       <= 1'b0;
        end else begin
            vdd_drop_prev_q <= flt_s[2];
            por_pulse       <= ~in_session & flt_s[2] & ~vdd_drop_prev_q;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    logic [SEQ_W-1:0] seq_cnt_q;
    logic             fault_latch_q;
    logic             release_now;

    assign release_now = (state_q == SEQ_HOLD) & cmd_n_s;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= SEQ_IDLE;
            seq_cnt_q <= '0;
        end else begin
            case (state_q)
                SEQ_IDLE: begin
                    seq_cnt_q <= '0;
                    if (!cmd_n_s && present_q && !fault_src) begin
                        state_q <= SEQ_ACTIVE;
                    end
                end
                SEQ_ACTIVE: begin
                    seq_cnt_q <= '0;
                    if (cmd_n_s || session_fault) begin
                        state_q <= SEQ_DEACT;
                    end
                end
                SEQ_DEACT: begin
                    if (seq_cnt_q == T15_END) begin
                        seq_cnt_q <= '0;
                        state_q   <= SEQ_HOLD;
                    end else begin
                        seq_cnt_q <= seq_cnt_q + SEQ_W'(1);
                    end
                end
                SEQ_HOLD: begin
                    seq_cnt_q <= '0;
                    if (cmd_n_s) begin
                        state_q <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_cnt_q <= '0;
                    state_q   <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Card contact enables, all set in one cycle on activation and released one by one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            card_rst_en <= 1'b0;
            card_clk_en <= 1'b0;
            card_io_en  <= 1'b0;
            vcc_en      <= 1'b0;
        end else if (state_q == SEQ_IDLE) begin
            if (!cmd_n_s && present_q && !fault_src) begin
                card_rst_en <= 1'b1;
                card_clk_en <= 1'b1;
                card_io_en  <= 1'b1;
                vcc_en      <= 1'b1;
            end
        end else if (state_q == SEQ_ACTIVE) begin
            if (cmd_n_s || session_fault) begin
                card_rst_en <= 1'b0;
            end
        end else if (state_q == SEQ_DEACT) begin
            if (seq_cnt_q == HALF_T_END) begin
                card_clk_en <= 1'b0;
            end
            if (seq_cnt_q == FULL_T_END) begin
                card_io_en <= 1'b0;
            end
            if (seq_cnt_q == T15_END) begin
                vcc_en <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Fault and presence output
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_latch_q <= 1'b0;
        end else if (session_fault) begin
            fault_latch_q <= 1'b1;
        end else if (release_now || !in_session) begin
            fault_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_n <= 1'b0;
        end else begin
            fault_n <= present_q & ~extract_evt & ~fault_latch_q & ~session_fault;
        end
    end

    // ------------------------------------------------------------------------
    // Supply level selection
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vcc_level <= VCC_3V0;
        end else if (lv_sel_s) begin
            vcc_level <= VCC_1V8;
        end else if (hv_sel_s) begin
            vcc_level <= VCC_5V0;
        end else begin
            vcc_level <= VCC_3V0;
        end
    end

    // ------------------------------------------------------------------------
    // Register port and interrupt
    // ------------------------------------------------------------------------
    logic [`CFS_EV_W-1:0] event_q;
    logic [`CFS_EV_W-1:0] mask_q;
    logic [`CFS_EV_W-1:0] event_set;
    logic [`CFS_EV_W-1:0] event_clr;

    always_comb begin
        event_set                  = '0;
        event_set[`CFS_EV_FAULT]   = session_fault;
        event_set[`CFS_EV_INSERT]  = insert_evt;
        event_set[`CFS_EV_EXTRACT] = extract_evt;
        event_set[`CFS_EV_POR]     = ~in_session & flt_s[2] & ~vdd_drop_prev_q;
    end

    assign event_clr = (reg_wr && reg_addr == `CFS_OFS_EVENT) ?
                       reg_wdata[`CFS_EV_W-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            event_q <= `CFS_RST_EVENT;
        end else begin
            event_q <= (event_q & ~event_clr) | event_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_q <= `CFS_RST_MASK;
        end else if (reg_wr && reg_addr == `CFS_OFS_MASK) begin
            mask_q <= reg_wdata[`CFS_EV_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((event_q & ~event_clr) | event_set) & mask_q);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `CFS_OFS_EVENT: reg_rdata <= {{(`CFS_DATA_W-`CFS_EV_W){1'b0}}, event_q};
                `CFS_OFS_MASK:  reg_rdata <= {{(`CFS_DATA_W-`CFS_EV_W){1'b0}}, mask_q};
                `CFS_OFS_STATE: reg_rdata <= {1'b0, state_q, vcc_level, in_session,
                                              present_q, fault_n};
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_fault_low;
        @(posedge core_clk) disable iff (rst)
        session_fault |=> !fault_n;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault output not low on fault");

    property p_auto_deact;
        @(posedge core_clk) disable iff (rst)
        (state_q == SEQ_ACTIVE) && session_fault |=> (state_q == SEQ_DEACT) && !card_rst_en;
    endproperty
    a_auto_deact: assert property (p_auto_deact) else $error("no deactivation on fault");

    property p_idle_presence;
        @(posedge core_clk) disable iff (rst)
        (state_q == SEQ_IDLE) && !fault_latch_q && !extract_evt |=> (fault_n == $past(present_q));
    endproperty
    a_idle_presence: assert property (p_idle_presence) else $error("idle output not presence");

    property p_por_idle;
        @(posedge core_clk) disable iff (rst)
        !in_session && flt_s[2] && !vdd_drop_prev_q |=> por_pulse ##1 !por_pulse;
    endproperty
    a_por_idle: assert property (p_por_idle) else $error("reset pulse missing or long");

    property p_no_idle_fault;
        @(posedge core_clk) disable iff (rst)
        (state_q == SEQ_IDLE) && (flt_s[3] || flt_s[0]) && !fault_latch_q |=>
            !fault_latch_q && (fault_n == $past(present_q && !extract_evt));
    endproperty
    a_no_idle_fault: assert property (p_no_idle_fault) else $error("fault flagged outside session");

    property p_release_high;
        @(posedge core_clk) disable iff (rst)
        release_now && present_q && present_raw ##1 (present_q && !extract_evt) |=> fault_n;
    endproperty
    a_release_high: assert property (p_release_high) else $error("output not high after release");

    property p_debounce_end;
        @(posedge core_clk) disable iff (rst)
        $rose(present_q) |-> ($past(db_cnt_q) == DB_END) && $past(present_raw);
    endproperty
    a_debounce_end: assert property (p_debounce_end) else $error("presence rose early");

    property p_extract;
        @(posedge core_clk) disable iff (rst)
        extract_evt |=> !present_q && !fault_n;
    endproperty
    a_extract: assert property (p_extract) else $error("extraction not acted on");

    property p_level;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> vcc_level == ($past(lv_sel_s) ? VCC_1V8 : ($past(hv_sel_s) ? VCC_5V0 : VCC_3V0));
    endproperty
    a_level: assert property (p_level) else $error("wrong supply level");

    property p_deact_order;
        @(posedge core_clk) disable iff (rst)
        $fell(vcc_en) |-> ($past(seq_cnt_q) == T15_END) && !card_clk_en && !card_io_en;
    endproperty
    a_deact_order: assert property (p_deact_order) else $error("supply fell out of order");

    property p_clk_half;
        @(posedge core_clk) disable iff (rst)
        $fell(card_clk_en) |-> ($past(seq_cnt_q) == HALF_T_END) && !card_rst_en;
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("clock stop at wrong time");

    property p_hold_fault;
        @(posedge core_clk) disable iff (rst)
        fault_latch_q && !release_now |=> !fault_n;
    endproperty
    a_hold_fault: assert property (p_hold_fault) else $error("fault indication dropped early");

endmodule

/* tb/card_host_model.sv */
// Host controller model driving the card power command
module card_host_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic fault_n,
    input  wire logic want_session,
    output logic      card_power_cmd_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // Starts only with a card seen; a low fault output ends the session at once
    always @(posedge core_clk) begin
        if (rst) begin
            card_power_cmd_n <= 1'b1;
        end else if (card_power_cmd_n && want_session && fault_n) begin
            card_power_cmd_n <= 1'b0;
        end else if (!card_power_cmd_n && (!want_session || !fault_n)) begin
            card_power_cmd_n <= 1'b1;
        end
    end
endmodule

/* tb/card_fault_supervisor_test.sv */
// Self-checking bench for the card fault supervisor
module card_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    import card_fault_supervisor_pkg::*;
    localparam int T   = 8;
    localparam int DEB = 16;
    logic       core_clk       = 1'b0;
    logic       rst            = 1'b1;
    logic       want           = 1'b0;
    logic [1:0] card_detect_in = 2'h2;
    logic       lvs            = 1'b0;
    logic       hvs            = 1'b0;
    logic [3:0] flt            = 4'h0;
    logic [3:0] reg_addr       = 4'h0;
    logic [7:0] reg_wdata      = 8'h00;
    logic       reg_wr         = 1'b0;
    logic       reg_rd         = 1'b0;
    logic       card_power_cmd_n;
    logic [7:0] reg_rdata;
    logic       fault_n;
    logic       por_pulse;
    logic       card_rst_en;
    logic       card_clk_en;
    logic       card_io_en;
    logic       vcc_en;
    logic       irq;
    vcc_level_e vcc_level;
    logic [4:0] e5;
    int         miscompares = 0;
    int         n_compared  = 0;

    assign e5 = {vcc_en, card_io_en, card_clk_en, card_rst_en, fault_n};
    always #2.5 core_clk = ~core_clk;

    card_host_model host (
        .core_clk        (core_clk),
        .rst             (rst),
        .fault_n         (fault_n),
        .want_session    (want),
        .card_power_cmd_n(card_power_cmd_n)
    );

    card_fault_supervisor #(.T_CYCLES(T), .DEBOUNCE_CYCLES(DEB)) dut (
        .core_clk(core_clk), .rst(rst), .card_power_cmd_n(card_power_cmd_n),
        .card_detect_in(card_detect_in), .low_volt_select(lvs), .high_volt_select(hvs),
        .vcc_overcurrent(flt[0]), .vdd_drop(flt[1]), .converter_fault(flt[2]),
        .over_temp(flt[3]), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_n(fault_n), .por_pulse(por_pulse),
        .card_rst_en(card_rst_en), .card_clk_en(card_clk_en), .card_io_en(card_io_en),
        .vcc_en(vcc_en), .vcc_level(vcc_level), .irq(irq)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic vcc_level_e exp_level(input logic l, input logic h);
        return l ? VCC_1V8 : (h ? VCC_5V0 : VCC_3V0);
    endfunction

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask

    task automatic wait_fault_n(input logic e, input int lim);
        for (int i = 0; i < lim && fault_n !== e; i++) @(negedge core_clk);
    endtask

    task automatic insert(input logic [1:0] p);
        if (fault_n !== 1'b1) begin
            @(posedge core_clk);
            card_detect_in <= p;
            repeat (DEB) @(negedge core_clk);
            chk(fault_n, 1'b0);
            wait_fault_n(1'b1, 12);
            chk(fault_n, 1'b1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        conclude();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [7:0] v;
        int         fall[5];
        logic       seen;
        void'($urandom(32'h0D66));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk(fault_n, 1'b0);
        rd_reg(4'hF, v);
        chk(v, 8'h00);
        rd_reg(4'h1, v);
        chk(v, 8'h00);
        wr_reg(4'h1, 8'h01);
        rd_reg(4'h1, v);
        chk(v, 8'h01);
        insert(2'h3);
        // Supply drop, overcurrent and heat with no session running
        @(posedge core_clk);
        flt  <= 4'hB;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            seen = seen | (por_pulse === 1'b1);
            chk(fault_n, 1'b1);
        end
        @(posedge core_clk);
        flt <= 4'h0;
        chk(seen, 1'b1);
        rd_reg(4'h2, v);
        chk(v & 8'h03, 8'h03);
        rd_reg(4'h0, v);
        chk(v & 8'h01, 8'h00);
        chk(irq, 1'b0);
        for (int k = 0; k < 6; k++) begin
            insert((k == 5) ? 2'h0 : 2'h3);
            @(posedge core_clk);
            {lvs, hvs} <= (k < 3) ? 2'(k) : 2'($urandom);
            want <= 1'b1;
            repeat (8) @(negedge core_clk);
            chk(vcc_level, exp_level(lvs, hvs));
            chk({card_rst_en, vcc_en}, 8'h03);
            @(posedge core_clk);
            if (k < 4) begin
                flt[k] <= 1'b1;
            end else begin
                card_detect_in <= 2'h2;
            end
            fall = '{default: -1};
            seen = 1'b0;
            for (int i = 0; i < 4 * T; i++) begin
                @(negedge core_clk);
                foreach (fall[j]) if (fall[j] < 0 && e5[j] === 1'b0) fall[j] = i;
                if (fall[0] >= 0 && fall[4] < 0) chk(fault_n, 1'b0);
                seen = seen | (fault_n === 1'b0);
                @(posedge core_clk);
                want <= ~seen;
                if (seen) flt <= 4'h0;
            end
            chk(fall[0] >= 0 && fall[0] <= fall[1], 1'b1);
            chk(fall[1] >= 0 && fall[1] <= 4, 1'b1);
            chk(8'(fall[2] - fall[1]), 8'(T / 2));
            chk(8'(fall[3] - fall[1]), 8'(T));
            chk(8'(fall[4] - fall[1]), 8'(3 * T / 2));
            wait_fault_n(k < 4, 10);
            chk(fault_n, k < 4);
            chk(irq, 1'b1);
            wr_reg(4'h0, 8'h0F);
            repeat (3) @(negedge core_clk);
            chk(irq, 1'b0);
            @(posedge core_clk);
            card_detect_in <= 2'h2;
            repeat (4) @(negedge core_clk);
            chk(fault_n, 1'b0);
        end
        conclude();
    end
endmodule
